// ---- hdl/adcc_pkg.sv ----
package adcc_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RES_W  = 10;
  localparam int CHAN_N = 12;
  localparam int CHS_W  = 4;
  localparam int IRQ_W  = 2;

  // ************************************************************
  // Register map.
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFS_CTRL0 = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL1 = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CTRL2 = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_RESH  = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_RESL  = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_ISTAT = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_ICLR  = 3'h6;
  localparam logic [ADDR_W-1:0] OFS_IEN   = 3'h7;

  // ************************************************************
  // Field positions and reset values.
  // ************************************************************
  localparam int B_CAL    = 7;
  localparam int B_UNIMP  = 6;
  localparam int B_CHS_HI = 5;
  localparam int B_CHS_LO = 2;
  localparam int B_GO     = 1;
  localparam int B_ON     = 0;
  localparam int B_JUST   = 7;
  localparam int B_ACQ_HI = 5;
  localparam int B_ACQ_LO = 3;
  localparam int B_CLK_HI = 2;
  localparam int B_CLK_LO = 0;
  localparam int I_DONE   = 0;
  localparam int I_CAL    = 1;
  localparam logic [DATA_W-1:0] CTRL_RST   = 8'h00;
  localparam logic [DATA_W-1:0] CTRL2_MASK = 8'hBF;
  localparam logic [DATA_W-1:0] BYTE_ZERO  = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_RST    = 2'h0;
  localparam logic [CHS_W-1:0]  CHS_LAST   = 4'hB;
  localparam logic [3:0]        BIT_MSB    = 4'h9;
  localparam logic [3:0]        CNT_ZERO   = 4'h0;
  localparam logic [3:0]        CNT_ONE    = 4'h1;
  localparam logic [RES_W-1:0]  RES_ZERO   = 10'h000;

  // ************************************************************
  // Timing: converter clock period is DIV_BASE system cycles
  // shifted left by the clock select field, which keeps every
  // comparator decision at least four cycles behind its code change.
  // ************************************************************
  localparam logic [9:0] DIV_BASE  = 10'h004;
  localparam logic [9:0] DIV_ONE   = 10'h001;
  localparam logic [9:0] DIV_ZERO  = 10'h000;
  localparam int         ACQ_SHIFT = 1;

  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_ACQ  = 2'b01,
    ADCC_CONV = 2'b11,
    ADCC_DONE = 2'b10
  } adcc_state_t;

  function automatic logic adcc_chan_valid(input logic [CHS_W-1:0] channel_select);
    return channel_select <= CHS_LAST;
  endfunction

  function automatic logic [CHAN_N-1:0] adcc_onehot(input logic [CHS_W-1:0] channel_select);
    logic [CHAN_N-1:0] oh;
    oh = '0;
    if (adcc_chan_valid(channel_select)) begin
      oh[channel_select] = 1'b1;
    end
    return oh;
  endfunction

endpackage

// ---- hdl/adcc_sar.sv ----
`timescale 1ns/1ns
module adcc_sar
  import adcc_pkg::*;
(
  input  wire logic             clk,       // System clock.
  input  wire logic             rst_n,     // Asynchronous reset, active low.
  input  wire logic             ce,        // Clock enable.
  input  wire logic             start,     // Start pulse.
  input  wire logic             abort,     // Stop and return to idle.
  input  wire logic             tick,      // Converter clock enable.
  input  wire logic [3:0]       acq_ticks, // Acquisition length in ticks.
  input  wire logic             cmp,       // Synchronised comparator.
  output logic                  busy,      // Conversion in progress.
  output logic                  sample,    // Sample switch closed.
  output logic                  done,      // Result ready pulse.
  output logic [RES_W-1:0]      code,      // Trial code to the DAC.
  output logic [RES_W-1:0]      result     // Last resolved code.
);

  adcc_state_t      state_reg, state_next;
  logic [3:0]       acq_cnt_reg;
  logic [3:0]       idx_reg;
  logic [RES_W-1:0] code_reg, code_next;
  logic [RES_W-1:0] result_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ADCC_IDLE: if (start) state_next = (acq_ticks != CNT_ZERO) ? ADCC_ACQ : ADCC_CONV;
      ADCC_ACQ:  if (tick && acq_cnt_reg == CNT_ONE) state_next = ADCC_CONV;
      ADCC_CONV: if (tick && idx_reg == CNT_ZERO) state_next = ADCC_DONE;
      ADCC_DONE: state_next = ADCC_IDLE;
    endcase
    if (abort) begin
      state_next = ADCC_IDLE;
    end
  end

  // Resolve the bit under trial and raise the next one.
  always_comb begin
    code_next = code_reg;
    code_next[idx_reg] = cmp;
    if (idx_reg != CNT_ZERO) begin
      code_next[idx_reg - CNT_ONE] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ADCC_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_cnt_reg <= CNT_ZERO;
    end else if (ce) begin
      if (state_reg == ADCC_IDLE) begin
        acq_cnt_reg <= acq_ticks;
      end else if (state_reg == ADCC_ACQ && tick) begin
        acq_cnt_reg <= acq_cnt_reg - CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= RES_ZERO;
      idx_reg  <= BIT_MSB;
    end else if (ce) begin
      if (state_reg != ADCC_CONV && state_next == ADCC_CONV) begin
        code_reg          <= RES_ZERO;
        code_reg[BIT_MSB] <= 1'b1;
        idx_reg           <= BIT_MSB;
      end else if (state_reg == ADCC_CONV && tick) begin
        code_reg <= code_next;
        idx_reg  <= idx_reg - CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= RES_ZERO;
    end else if (ce && state_reg == ADCC_CONV && state_next == ADCC_DONE) begin
      result_reg <= code_next;
    end
  end

  assign busy   = (state_reg != ADCC_IDLE);
  assign sample = (state_reg == ADCC_ACQ);
  assign done   = (state_reg == ADCC_DONE);
  assign code   = code_reg;
  assign result = result_reg;

  property p_sar_done_once;
    @(posedge clk) disable iff (!rst_n || !ce)
      done |=> !done && !busy;
  endproperty
  a_sar_done_once: assert property (p_sar_done_once) else $error("done not one cycle");

endmodule // adcc_sar

// ---- hdl/adcc_top.sv ----
`timescale 1ns/1ns
module adcc_top
  import adcc_pkg::*;
(
  input  wire logic              clk,         // System clock, 250 MHz.
  input  wire logic              rst_n,       // Asynchronous reset, active low.
  input  wire logic              ce,          // Clock enable, freezes all state.
  input  wire logic [ADDR_W-1:0] reg_addr,    // Register address.
  input  wire logic [DATA_W-1:0] reg_wdata,   // Register write data.
  input  wire logic              reg_wr,      // Write strobe.
  input  wire logic              reg_rd,      // Read strobe.
  output logic      [DATA_W-1:0] reg_rdata,   // Read data, cycle after strobe.
  output logic                   irq,         // Interrupt, level, active high.
  output logic                   conv_power,  // Converter powered.
  output logic      [CHAN_N-1:0] chan_sel,    // One-hot input multiplexer select.
  output logic                   sample_hold, // Sample switch closed.
  output logic                   cal_mode,    // Calibration cycle running.
  output logic      [RES_W-1:0]  dac_code,    // Trial code to the DAC.
  output logic      [DATA_W-1:0] port_cfg,    // Pin configuration byte.
  input  wire logic              cmp_in       // Analog comparator output.
);

  // ************************************************************
  // Declarations.
  // ************************************************************
  logic              cal_req_reg;
  logic [CHS_W-1:0]  chs_reg;
  logic              go_reg;
  logic              on_reg;
  logic [DATA_W-1:0] ctrl1_reg;
  logic [DATA_W-1:0] ctrl2_reg;
  logic [RES_W-1:0]  res_reg;
  logic [RES_W-1:0]  offset_reg;
  logic [IRQ_W-1:0]  istat_reg;
  logic [IRQ_W-1:0]  ien_reg;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [CHAN_N-1:0] chan_reg;
  logic              cal_act_reg;
  logic              cmp_meta_reg;
  logic              cmp_sync_reg;
  logic [9:0]        div_cnt_reg;
  logic [9:0]        div_period;
  logic              tick;
  logic              wr_ctrl0;
  logic              start;
  logic              abort;
  logic              sar_busy;
  logic              sar_sample;
  logic              sar_done;
  logic [RES_W-1:0]  sar_code;
  logic [RES_W-1:0]  sar_result;
  logic [RES_W-1:0]  res_corr;
  logic [3:0]        acq_ticks;
  logic [DATA_W-1:0] ctrl0_view;
  logic [DATA_W-1:0] resh_view;
  logic [DATA_W-1:0] resl_view;
  logic [IRQ_W-1:0]  ev_set;
  logic [IRQ_W-1:0]  ev_clr;

  // ************************************************************
  // Command decode.
  // ************************************************************
  assign wr_ctrl0 = reg_wr && (reg_addr == OFS_CTRL0);
  // A start needs the module already on and kept on by the same write.
  assign start = wr_ctrl0 && reg_wdata[B_GO] && reg_wdata[B_ON] && on_reg && !go_reg;
  assign abort = wr_ctrl0 && !reg_wdata[B_ON];

  // ************************************************************
  // Control register 0.
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_req_reg <= CTRL_RST[B_CAL];
      chs_reg     <= CTRL_RST[B_CHS_HI:B_CHS_LO];
      on_reg      <= CTRL_RST[B_ON];
    end else if (ce && wr_ctrl0) begin
      cal_req_reg <= reg_wdata[B_CAL];
      chs_reg     <= reg_wdata[B_CHS_HI:B_CHS_LO];
      on_reg      <= reg_wdata[B_ON];
    end
  end

  // The status bit is set only by a start and cleared at done or by an abort.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      go_reg <= CTRL_RST[B_GO];
    end else if (ce) begin
      if (start) begin
        go_reg <= 1'b1;
      end else if (sar_done || abort) begin
        go_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Control registers 1 and 2.
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_reg <= CTRL_RST;
    end else if (ce && reg_wr && reg_addr == OFS_CTRL1) begin
      ctrl1_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl2_reg <= CTRL_RST;
    end else if (ce && reg_wr && reg_addr == OFS_CTRL2) begin
      ctrl2_reg <= reg_wdata & CTRL2_MASK;
    end
  end

  // ************************************************************
  // Converter clock divider, held in reset while idle.
  // ************************************************************
  assign div_period = DIV_BASE << ctrl2_reg[B_CLK_HI:B_CLK_LO];
  assign tick       = sar_busy && (div_cnt_reg == div_period - DIV_ONE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= DIV_ZERO;
    end else if (ce) begin
      if (!sar_busy || tick) begin
        div_cnt_reg <= DIV_ZERO;
      end else begin
        div_cnt_reg <= div_cnt_reg + DIV_ONE;
      end
    end
  end

  assign acq_ticks = 4'({1'b0, ctrl2_reg[B_ACQ_HI:B_ACQ_LO]} << ACQ_SHIFT);

  // ************************************************************
  // Comparator synchroniser.
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
    end else if (ce) begin
      cmp_meta_reg <= cmp_in;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // ************************************************************
  // Successive-approximation engine.
  // ************************************************************
  adcc_sar u_sar (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .start     (start),
    .abort     (abort),
    .tick      (tick),
    .acq_ticks (acq_ticks),
    .cmp       (cmp_sync_reg),
    .busy      (sar_busy),
    .sample    (sar_sample),
    .done      (sar_done),
    .code      (sar_code),
    .result    (sar_result)
  );

  // Channel and calibration mode are latched at start so that a
  // control 0 write during a conversion cannot change them unless it clears the on bit and aborts.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_reg    <= '0;
      cal_act_reg <= 1'b0;
    end else if (ce) begin
      if (start) begin
        chan_reg    <= adcc_onehot(reg_wdata[B_CHS_HI:B_CHS_LO]);
        cal_act_reg <= reg_wdata[B_CAL];
      end else if (sar_done || abort) begin
        chan_reg    <= '0;
        cal_act_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Result and calibration offset.
  // ************************************************************
  assign res_corr = (sar_result > offset_reg) ? sar_result - offset_reg : RES_ZERO;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_reg <= RES_ZERO;
    end else if (ce && sar_done && cal_act_reg) begin
      offset_reg <= sar_result;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_reg <= RES_ZERO;
    end else if (ce && sar_done && !cal_act_reg) begin
      res_reg <= res_corr;
    end
  end

  // ************************************************************
  // Interrupt status, clear and enable.
  // ************************************************************
  assign ev_set = {sar_done && cal_act_reg, sar_done && !cal_act_reg};
  assign ev_clr = (reg_wr && reg_addr == OFS_ICLR) ? reg_wdata[IRQ_W-1:0] : IRQ_RST;

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_reg <= IRQ_RST;
    end else if (ce) begin
      istat_reg <= (istat_reg & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ien_reg <= IRQ_RST;
    end else if (ce && reg_wr && reg_addr == OFS_IEN) begin
      ien_reg <= reg_wdata[IRQ_W-1:0];
    end
  end

  // ************************************************************
  // Read path.
  // ************************************************************
  always_comb begin
    ctrl0_view           = BYTE_ZERO;
    ctrl0_view[B_CAL]    = cal_req_reg;
    ctrl0_view[B_UNIMP]  = 1'b0;
    ctrl0_view[B_CHS_HI:B_CHS_LO] = chs_reg;
    ctrl0_view[B_GO]     = go_reg && on_reg;
    ctrl0_view[B_ON]     = on_reg;
  end

  // Right justified puts bits 9..8 in the high byte, left justified
  // puts bits 9..2 there and bits 1..0 at the top of the low byte.
  always_comb begin
    if (ctrl2_reg[B_JUST]) begin
      resh_view = {6'h00, res_reg[9:8]};
      resl_view = res_reg[7:0];
    end else begin
      resh_view = res_reg[9:2];
      resl_view = {res_reg[1:0], 6'h00};
    end
  end

  always_comb begin
    rdata_next = BYTE_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL0: rdata_next = ctrl0_view;
        OFS_CTRL1: rdata_next = ctrl1_reg;
        OFS_CTRL2: rdata_next = ctrl2_reg;
        OFS_RESH:  rdata_next = resh_view;
        OFS_RESL:  rdata_next = resl_view;
        OFS_ISTAT: rdata_next = {6'h00, istat_reg};
        OFS_ICLR:  rdata_next = BYTE_ZERO;
        OFS_IEN:   rdata_next = {6'h00, ien_reg};
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= BYTE_ZERO;
    end else if (ce) begin
      rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // Outputs.
  // ************************************************************
  assign reg_rdata   = rdata_reg;
  assign irq         = |(istat_reg & ien_reg);
  assign conv_power  = on_reg;
  assign chan_sel    = chan_reg;
  assign sample_hold = sar_sample;
  assign cal_mode    = cal_act_reg;
  assign dac_code    = sar_code;
  assign port_cfg    = ctrl1_reg;

  // ************************************************************
  // Assertions.
  // ************************************************************
  property p_start_busy;
    @(posedge clk) disable iff (!rst_n || !ce)
      start |=> go_reg && sar_busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not begin");

  property p_done_clears;
    @(posedge clk) disable iff (!rst_n || !ce)
      sar_done && !cal_act_reg |=> !go_reg && res_reg == $past(res_corr);
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("status not cleared");

  property p_disable_stops;
    @(posedge clk) disable iff (!rst_n || !ce)
      abort |=> !sar_busy && !go_reg && chan_sel == '0;
  endproperty
  a_disable_stops: assert property (p_disable_stops) else $error("disable ignored");

  property p_unimp_zero;
    @(posedge clk) disable iff (!rst_n || !ce)
      reg_rd && reg_addr == OFS_CTRL0 |=> !reg_rdata[B_UNIMP];
  endproperty
  a_unimp_zero: assert property (p_unimp_zero) else $error("bit 6 not zero");

  property p_status_read;
    @(posedge clk) disable iff (!rst_n || !ce)
      reg_rd && reg_addr == OFS_CTRL0 && on_reg |=> reg_rdata[B_GO] == $past(sar_busy);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status mismatch");

  property p_chan_sel;
    @(posedge clk) disable iff (!rst_n || !ce)
      start |=> chan_sel == adcc_onehot($past(reg_wdata[B_CHS_HI:B_CHS_LO]))
                && $onehot0(chan_sel);
  endproperty
  a_chan_sel: assert property (p_chan_sel) else $error("channel select wrong");

  property p_power;
    @(posedge clk) disable iff (!rst_n || !ce)
      wr_ctrl0 |=> conv_power == $past(reg_wdata[B_ON]);
  endproperty
  a_power: assert property (p_power) else $error("power not following enable");

  property p_cal_keeps_result;
    @(posedge clk) disable iff (!rst_n || !ce)
      sar_done && cal_act_reg |=> $stable(res_reg) && offset_reg == $past(sar_result);
  endproperty
  a_cal_keeps_result: assert property (p_cal_keeps_result) else $error("cal wrote result");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n || !ce)
      ev_set[I_DONE] |=> istat_reg[I_DONE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  c_conversion: cover property (@(posedge clk) disable iff (!rst_n)
    sar_done && !cal_act_reg);
  c_calibration: cover property (@(posedge clk) disable iff (!rst_n)
    sar_done && cal_act_reg);
  c_abort: cover property (@(posedge clk) disable iff (!rst_n)
    abort && sar_busy);

endmodule // adcc_top

// ---- sim/adcc_analog_model.sv ----
`timescale 1ns/1ns
module adcc_analog_model
  import adcc_pkg::*;
(
  input  wire logic              clk,          // System clock.
  input  wire logic              power,        // Converter powered.
  input  wire logic [CHAN_N-1:0] sel,          // One-hot channel select.
  input  wire logic [RES_W-1:0]  code,         // Trial code from the DAC.
  input  wire logic [RES_W-1:0]  vin [CHAN_N], // Input levels.
  output logic                   cmp           // Comparator output.
);
  logic [RES_W-1:0] lvl;
  logic             tgl = 1'b0;

  always_comb begin
    lvl = '0;
    for (int i = 0; i < CHAN_N; i++) begin
      if (sel[i]) begin
        lvl = vin[i];
      end
    end
  end

  // A floating input gives no stable decision, so it wanders every cycle.
  always @(posedge clk) begin
    tgl <= !tgl;
  end

  assign cmp = !power ? 1'b0 : (sel == '0) ? tgl : (lvl >= code);
endmodule // adcc_analog_model

// ---- sim/test_adc_control_channel_select.sv ----
`timescale 1ns/1ns
module test_adc_control_channel_select
  import adcc_pkg::*;
;
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic [DATA_W-1:0] port_cfg;
  logic              reg_wr;
  logic              reg_rd;
  logic              irq;
  logic              conv_power;
  logic              sample_hold;
  logic              cal_mode;
  logic              cmp_in;
  logic [CHAN_N-1:0] chan_sel;
  logic [RES_W-1:0]  dac_code;
  logic [RES_W-1:0]  vin [CHAN_N];
  logic [7:0]        d;
  logic [7:0]        k;
  logic [7:0]        hold;
  logic [9:0]        ex;
  logic [3:0]        ch;
  int                err_count = 0;
  int                samples_checked = 0;

  adcc_top i_adcc_top (.clk(clk), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .conv_power(conv_power), .chan_sel(chan_sel), .sample_hold(sample_hold),
    .cal_mode(cal_mode), .dac_code(dac_code), .port_cfg(port_cfg), .cmp_in(cmp_in));
  adcc_analog_model i_adcc_analog_model (.clk(clk), .power(conv_power), .sel(chan_sel),
    .code(dac_code), .vin(vin), .cmp(cmp_in));

  // ******************************
  // Bus tasks and checks.
  // ******************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic results;
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string n, input logic [11:0] e, input logic [11:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic rchk(input string n, input logic [2:0] a, input logic [7:0] e);
    rd(a, d);
    check(n, {4'h0, e}, {4'h0, d});
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd(OFS_CTRL0, d);
      n++;
    end while (d[B_GO] !== 1'b0 && n < 5000);
    if (d[B_GO] !== 1'b0) begin
      err_count++;
      results();
    end
  endtask

  function automatic logic [7:0] rexp(input logic [9:0] v, input logic rj, input logic hi);
    if (rj) return hi ? {6'h00, v[9:8]} : v[7:0];
    return hi ? v[9:2] : {v[1:0], 6'h00};
  endfunction

  task automatic conv(input logic [3:0] c, input logic [7:0] kk, input logic cal);
    wr(OFS_CTRL2, kk);
    wr(OFS_CTRL0, {cal, 1'b0, c, 2'h3});
    @(posedge clk);
    #1 check("chan_sel", (c <= 4'hB) ? (12'h001 << c) : 12'h000, chan_sel);
    check("cal_mode", {11'h000, cal}, {11'h000, cal_mode});
    rchk("go", OFS_CTRL0, {cal, 1'b0, c, 2'h3});
  endtask

  // ******************************
  // Main sequence.
  // ******************************
  initial begin
    rst_n     = 1'b0;
    reg_addr  = 3'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    for (int j = 0; j < CHAN_N; j++) vin[j] = 10'h000;
    void'($urandom(32'h15C8));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rchk("reset", a[2:0], 8'h00);
    check("power", 12'h000, {11'h000, conv_power});
    wr(OFS_CTRL0, 8'h43);
    rchk("ctrl0", OFS_CTRL0, 8'h01);
    check("power", 12'h001, {11'h000, conv_power});
    wr(OFS_CTRL1, 8'hA5);
    check("port_cfg", 12'h0A5, {4'h0, port_cfg});
    wr(OFS_CTRL2, 8'hFF);
    rchk("ctrl2", OFS_CTRL2, 8'hBF);
    wr(OFS_IEN, 8'h03);
    for (int i = 0; i < 30; i++) begin
      for (int j = 0; j < CHAN_N; j++) vin[j] <= 10'($urandom_range(1023));
      ch = (i < 4) ? 4'hC + 4'(i) : (i == 4) ? 4'hB : (i == 5) ? 4'h0 : 4'($urandom_range(11));
      k = {1'($urandom), 1'b0, 3'($urandom), 2'h0, 1'($urandom)};
      conv(ch, k, 1'b0);
      wait_idle();
      check("irq", 12'h001, {11'h000, irq});
      if (ch <= 4'hB) begin
        rchk("res_hi", OFS_RESH, rexp(vin[ch], k[B_JUST], 1'b1));
        rchk("res_lo", OFS_RESL, rexp(vin[ch], k[B_JUST], 1'b0));
      end
      rchk("istat", OFS_ISTAT, 8'h01);
      wr(OFS_ICLR, 8'h01);
      check("irq", 12'h000, {11'h000, irq});
    end
    wr(OFS_IEN, 8'h00);
    conv(4'h2, 8'h00, 1'b0);
    check("dac_code", 12'h200, {2'h0, dac_code});
    wait_idle();
    check("irq masked", 12'h000, {11'h000, irq});
    rchk("istat", OFS_ISTAT, 8'h01);
    wr(OFS_ICLR, 8'h01);
    conv(4'h5, 8'h3F, 1'b0);
    check("sample on", 12'h001, {11'h000, sample_hold});
    wr(OFS_CTRL0, 8'h14);
    check("chan_sel", 12'h000, chan_sel);
    check("power", 12'h000, {11'h000, conv_power});
    check("sample", 12'h000, {11'h000, sample_hold});
    repeat (50) @(posedge clk);
    rchk("ctrl0", OFS_CTRL0, 8'h14);
    rchk("istat", OFS_ISTAT, 8'h00);
    wr(OFS_CTRL0, 8'h01);
    rd(OFS_RESH, hold);
    conv(4'h3, 8'h00, 1'b1);
    wait_idle();
    rchk("istat", OFS_ISTAT, 8'h02);
    rchk("res_hi", OFS_RESH, hold);
    ex = (vin[4] > vin[3]) ? vin[4] - vin[3] : 10'h000;
    conv(4'h4, 8'h80, 1'b0);
    wait_idle();
    rchk("res_hi cal", OFS_RESH, rexp(ex, 1'b1, 1'b1));
    rchk("res_lo cal", OFS_RESL, rexp(ex, 1'b1, 1'b0));
    results();
  end
endmodule // test_adc_control_channel_select
